// file: logic/lpsc_ctrl.sv
// low-power stop/wait controller: halt and idle entry, wake-up, restart delay, pin hold
// assumes one 200 MHz clock, synchronous active-high reset, core strobes on the same clock
//
// Contract
// - halt with halt-disable clear enters the lowest power state
// - halt with halt-disable set acts as a no-operation
// - while halted every clock and the oscillator are stopped
// - halt ends only on reset, nonmaskable request, or unmasked maskable request
// - nonmaskable request wakes regardless of its mask flag
// - nonmaskable wake with mask clear starts with stacking then service
// - nonmaskable wake with mask set resumes after the halt, no service
// - reset always ends halt and restarts from the reset vector
// - internal oscillator wake waits 4064 cycles before resuming
// - restart delay select zero shortens the wake delay to four cycles
// - idle hold in expanded modes drives stack pointer minus 8 on address
// - steady-state outputs keep their entry level through the low-power period
// - idle hold stacks state, stops execution, oscillator runs, exits on interrupt
// - idle hold with interrupts masked and watchdog off stops the timers
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps

module lpsc_ctrl (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire lpsc_pkg::lpsc_core_s core_i, // instruction strobes and flags
  input wire logic nonmaskable_request_pin_n, // nonmaskable request pin, active low
  input wire logic irq_pin_n, // maskable request pin, active low
  input wire logic [7:0] ss_pins_i, // levels of the steady-state outputs
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hsel, // ahb slave select
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  output logic clk_run, // clock and oscillator enable
  output logic core_stall, // execution stopped
  output logic timer_run, // timer system enable
  output logic resume_next, // pulse: continue after the halt instruction
  output logic resume_stack, // pulse: start stacking and service sequence
  output logic resume_vector, // pulse: fetch the reset vector
  output logic nop_done, // pulse: halt treated as no-operation
  output logic stack_req, // pulse: stack machine state on idle entry
  output logic addr_oe, // address bus driven with stack address
  output logic [15:0] addr_o, // address during idle hold
  output logic [7:0] ss_pins_o // held steady-state output levels
);

  lpsc_pkg::lpsc_state_e state_r;
  logic [2:0] ctrl_r;
  logic [11:0] delay_cnt_r;
  logic [lpsc_pkg::SYNC_DEPTH-1:0] nmi_sync_r;
  logic [lpsc_pkg::SYNC_DEPTH-1:0] irq_sync_r;
  logic nmi_lvl_r;
  logic irq_lvl_r;
  logic wake_stack_r;
  logic ap_valid_r;
  logic ap_write_r;
  logic [7:0] ap_addr_r;
  logic nmi_act;
  logic irq_act;
  logic halt_go;
  logic [11:0] delay_seen_r; // cycles spent in the restart delay, checks only
  logic delay_long_r; // long delay chosen at wake-up, checks only

  // request pins: three-stage filter, level changes when stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_sync_r <= '1;
      irq_sync_r <= '1;
    end else begin
      nmi_sync_r <= {nmi_sync_r[1:0], nonmaskable_request_pin_n};
      irq_sync_r <= {irq_sync_r[1:0], irq_pin_n};
    end
  end

  // filtered pin levels
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_lvl_r <= 1'b1;
      irq_lvl_r <= 1'b1;
    end else begin
      if (nmi_sync_r[1] == nmi_sync_r[2]) begin
        nmi_lvl_r <= nmi_sync_r[2];
      end
      if (irq_sync_r[1] == irq_sync_r[2]) begin
        irq_lvl_r <= irq_sync_r[2];
      end
    end
  end

  // wake conditions from the filtered requests
  assign nmi_act = !nmi_lvl_r;
  assign irq_act = !irq_lvl_r && !core_i.irq_mask;
  assign halt_go = core_i.halt_op && !core_i.halt_dis;

  // low-power state machine and resume path selection
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= lpsc_pkg::ST_RUN;
      delay_cnt_r <= '0;
      wake_stack_r <= 1'b0;
    end else begin
      case (state_r)
        lpsc_pkg::ST_RUN: begin
          if (halt_go) begin
            state_r <= lpsc_pkg::ST_HALT;
          end else if (core_i.wait_op) begin
            state_r <= lpsc_pkg::ST_WAIT;
          end
        end
        lpsc_pkg::ST_WAIT: begin
          if (nmi_act && !core_i.nmi_mask) begin
            state_r <= lpsc_pkg::ST_RESUME;
            wake_stack_r <= 1'b1;
          end else if (irq_act) begin
            state_r <= lpsc_pkg::ST_RESUME;
            wake_stack_r <= 1'b1;
          end
        end
        lpsc_pkg::ST_HALT: begin
          if (nmi_act) begin
            state_r <= lpsc_pkg::ST_DELAY;
            wake_stack_r <= !core_i.nmi_mask;
            delay_cnt_r <= ctrl_r[lpsc_pkg::CTRL_DELAY_BIT] ? lpsc_pkg::LONG_DELAY
                                                            : lpsc_pkg::SHORT_DELAY;
          end else if (irq_act) begin
            state_r <= lpsc_pkg::ST_DELAY;
            wake_stack_r <= 1'b1;
            delay_cnt_r <= ctrl_r[lpsc_pkg::CTRL_DELAY_BIT] ? lpsc_pkg::LONG_DELAY
                                                            : lpsc_pkg::SHORT_DELAY;
          end
        end
        lpsc_pkg::ST_DELAY: begin
          delay_cnt_r <= delay_cnt_r - 12'h001;
          if (delay_cnt_r == 12'h001) begin
            state_r <= lpsc_pkg::ST_RESUME;
          end
        end
        default: begin
          state_r <= lpsc_pkg::ST_RUN;
          wake_stack_r <= 1'b0;
        end
      endcase
    end
  end

  // clock, stall and timer enables
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_run <= 1'b1;
      core_stall <= 1'b0;
      timer_run <= 1'b1;
    end else begin
      clk_run <= !(state_r == lpsc_pkg::ST_HALT) && !(state_r == lpsc_pkg::ST_RUN && halt_go);
      core_stall <= (state_r != lpsc_pkg::ST_RUN) || halt_go || core_i.wait_op;
      timer_run <= !((state_r == lpsc_pkg::ST_WAIT) && core_i.irq_mask
                     && !ctrl_r[lpsc_pkg::CTRL_WDOG_BIT]) && (state_r != lpsc_pkg::ST_HALT);
    end
  end

  // one-cycle result pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      resume_next <= 1'b0;
      resume_stack <= 1'b0;
      resume_vector <= 1'b1;
      nop_done <= 1'b0;
      stack_req <= 1'b0;
    end else begin
      resume_next <= (state_r == lpsc_pkg::ST_RESUME) && !wake_stack_r;
      resume_stack <= (state_r == lpsc_pkg::ST_RESUME) && wake_stack_r;
      resume_vector <= 1'b0;
      nop_done <= (state_r == lpsc_pkg::ST_RUN) && core_i.halt_op && core_i.halt_dis;
      stack_req <= (state_r == lpsc_pkg::ST_RUN) && !halt_go && core_i.wait_op;
    end
  end

  // idle-hold address output and steady-state pin hold
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_oe <= 1'b0;
      addr_o <= '0;
      ss_pins_o <= '0;
    end else begin
      if (state_r == lpsc_pkg::ST_RUN) begin
        ss_pins_o <= ss_pins_i;
        if (core_i.wait_op && !halt_go) begin
          addr_o <= core_i.sp - lpsc_pkg::STACK_ADJ;
        end
      end
      addr_oe <= (state_r == lpsc_pkg::ST_WAIT) && ctrl_r[lpsc_pkg::CTRL_EXP_BIT];
    end
  end

  // ahb address phase capture
  always_ff @(posedge clk) begin
    if (rst) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= '0;
    end else if (hready) begin
      ap_valid_r <= hsel && htrans[1];
      ap_write_r <= hwrite;
      ap_addr_r <= haddr[7:0];
    end
  end

  // control register write
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= lpsc_pkg::CTRL_RST;
    end else if (ap_valid_r && ap_write_r && ap_addr_r == lpsc_pkg::CTRL_OFFS) begin
      ctrl_r <= hwdata[2:0];
    end
  end

  // read data, registered from the address phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == lpsc_pkg::CTRL_OFFS) begin
        hrdata <= {29'h0, ctrl_r};
      end else if (haddr[7:0] == lpsc_pkg::STAT_OFFS) begin
        hrdata <= {29'h0, state_r};
      end else if (haddr[7:0] == lpsc_pkg::SPAD_OFFS) begin
        hrdata <= {16'h0, addr_o};
      end else begin
        hrdata <= '0;
      end
    end
  end

  // zero wait-state slave, always okay
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // check helper: count cycles spent in the restart delay
  always_ff @(posedge clk) begin
    if (rst || state_r != lpsc_pkg::ST_DELAY) begin
      delay_seen_r <= 12'h001;
    end else begin
      delay_seen_r <= delay_seen_r + 12'h001;
    end
  end

  // check helper: delay length selected at the moment of wake-up
  always_ff @(posedge clk) begin
    if (rst) begin
      delay_long_r <= 1'b0;
    end else if (state_r == lpsc_pkg::ST_HALT && (nmi_act || irq_act)) begin
      delay_long_r <= ctrl_r[lpsc_pkg::CTRL_DELAY_BIT];
    end
  end

  // checks
  halt_entry_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_RUN && halt_go) |=> state_r == lpsc_pkg::ST_HALT)
    else $error("halt not entered");
  halt_nop_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_RUN && core_i.halt_op && core_i.halt_dis) |=> nop_done)
    else $error("disabled halt not a nop");
  clk_stop_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_HALT) |=> !clk_run)
    else $error("clock runs while halted");
  halt_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_HALT && !nmi_act && !irq_act) |=> state_r == lpsc_pkg::ST_HALT)
    else $error("halt left without cause");
  nmi_wake_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_HALT && nmi_act) |=> state_r == lpsc_pkg::ST_DELAY)
    else $error("nonmaskable request ignored");
  short_delay_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_HALT && nmi_act && !ctrl_r[lpsc_pkg::CTRL_DELAY_BIT])
    |=> ##5 resume_next || resume_stack)
    else $error("short delay wrong");
  nmi_path_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_RESUME && !wake_stack_r) |=> resume_next && !resume_stack)
    else $error("wrong resume path");
  sp_addr_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_RUN && core_i.wait_op && !halt_go)
    |=> addr_o == $past(core_i.sp) - lpsc_pkg::STACK_ADJ)
    else $error("idle address wrong");
  ss_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_HALT && $past(state_r) == lpsc_pkg::ST_HALT) |-> $stable(ss_pins_o))
    else $error("steady pins changed");
  halt_stall_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_HALT)
    |=> core_stall && !timer_run)
    else $error("core or timers run while halted");
  nop_stays_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_RUN && core_i.halt_op && core_i.halt_dis && !core_i.wait_op)
    |=> state_r == lpsc_pkg::ST_RUN)
    else $error("disabled halt left run");

  // restart delay length, oscillator restart and resume paths
  restart_len_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_DELAY)
    |=> (state_r == lpsc_pkg::ST_RESUME) == ($past(delay_seen_r)
        == (delay_long_r ? lpsc_pkg::LONG_DELAY : lpsc_pkg::SHORT_DELAY)))
    else $error("restart delay length wrong");
  osc_restart_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_DELAY)
    |=> clk_run)
    else $error("oscillator stopped during restart delay");
  irq_wake_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_HALT && !nmi_act && irq_act)
    |=> state_r == lpsc_pkg::ST_DELAY && wake_stack_r)
    else $error("maskable wake path wrong");
  stack_path_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_RESUME && wake_stack_r)
    |=> resume_stack && !resume_next)
    else $error("stacking path not taken");
  reset_vec_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst)
    |-> resume_vector ##1 !resume_vector)
    else $error("reset vector pulse wrong");

  // idle hold behaviour
  wait_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_WAIT && !(nmi_act && !core_i.nmi_mask) && !irq_act)
    |=> state_r == lpsc_pkg::ST_WAIT)
    else $error("idle hold left without cause");
  timer_off_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_WAIT && core_i.irq_mask && !ctrl_r[lpsc_pkg::CTRL_WDOG_BIT])
    |=> !timer_run)
    else $error("timers run in masked idle hold");
  addr_drive_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == lpsc_pkg::ST_WAIT && ctrl_r[lpsc_pkg::CTRL_EXP_BIT])
    |=> addr_oe)
    else $error("idle address not driven");

endmodule // lpsc_ctrl

// file: logic/lpsc_pkg.sv
// package for the low-power stop/wait controller: states, timing counts, carriers
// assumes a single 200 MHz clock domain and an ahb-lite register port
package lpsc_pkg;

  // register byte addresses
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] STAT_OFFS = 8'h04;
  localparam logic [7:0] SPAD_OFFS = 8'h08;

  // control register field positions
  localparam int CTRL_DELAY_BIT = 0;
  localparam int CTRL_WDOG_BIT = 1;
  localparam int CTRL_EXP_BIT = 2;

  // control register reset value: long delay selected, watchdog off, single chip
  localparam logic [2:0] CTRL_RST = 3'h1;

  // restart delays in clock cycles of the core clock
  localparam logic [11:0] LONG_DELAY = 12'hfe0; // 4064 cycles
  localparam logic [11:0] SHORT_DELAY = 12'h004; // 4 cycles

  // stack frame size subtracted from the stack pointer on the address bus
  localparam logic [15:0] STACK_ADJ = 16'h0008;

  // request edge filter depth
  localparam int SYNC_DEPTH = 3;

  // controller states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_HALT = 3'b010,
    ST_DELAY = 3'b011,
    ST_RESUME = 3'b100
  } lpsc_state_e;

  // how execution continues after leaving a low-power state
  typedef enum logic [1:0] {
    RES_NONE = 2'b00,
    RES_NEXT = 2'b01,
    RES_STACK = 2'b10
  } lpsc_resume_e;

  // instruction request carrier from the core
  typedef struct packed {
    logic halt_op;
    logic wait_op;
    logic halt_dis;
    logic irq_mask;
    logic nmi_mask;
    logic [15:0] sp;
  } lpsc_core_s;

endpackage

// file: test/low_power_stop_wait_control_test.sv
// testbench for the low-power controller: halt, wake paths, restart delay, idle hold
// assumes a 200 MHz clock, registers reached over ahb-lite with zero wait states
`timescale 1ns/10ps

module low_power_stop_wait_control_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lpsc_pkg::lpsc_core_s core = '0;
  logic [7:0] ss_pins_i = 8'h00;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0, hsel = 1'b0, hreadyout, hresp;
  logic clk_run, core_stall, timer_run, resume_next, resume_stack, resume_vector;
  logic nop_done, stack_req, addr_oe, nmi_n, irq_n, sn, ss;
  logic fire_nmi = 1'b0, fire_irq = 1'b0;
  logic [15:0] addr_o;
  logic [7:0] ss_pins_o;
  int miscompares = 0, check_count = 0;

  // 5 ns clock
  always #2.5 clk = ~clk;

  lpsc_ctrl lpsc_ctrl_inst (.clk(clk), .rst(rst), .core_i(core),
    .nonmaskable_request_pin_n(nmi_n), .irq_pin_n(irq_n), .ss_pins_i(ss_pins_i),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hsel(hsel), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .clk_run(clk_run), .core_stall(core_stall), .timer_run(timer_run),
    .resume_next(resume_next), .resume_stack(resume_stack),
    .resume_vector(resume_vector), .nop_done(nop_done), .stack_req(stack_req),
    .addr_oe(addr_oe), .addr_o(addr_o), .ss_pins_o(ss_pins_o));

  lpsc_req_src lpsc_req_src_inst (.clk(clk), .rst(rst), .fire_nmi(fire_nmi),
    .fire_irq(fire_irq), .ack(resume_next | resume_stack), .nmi_n(nmi_n), .irq_n(irq_n));

  // compare one value and count it
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single ahb transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  // one-cycle halt (h=1) or idle hold (h=0) strobe, watching the reply pulses
  task automatic op(input logic h);
    @(posedge clk);
    core.halt_op <= h;
    core.wait_op <= !h;
    @(posedge clk);
    core.halt_op <= 1'b0;
    core.wait_op <= 1'b0;
    sn = 1'b0;
    ss = 1'b0;
    repeat (4) begin
      @(posedge clk);
      sn |= nop_done;
      ss |= stack_req;
    end
  endtask

  // raise a request pin through the source model
  task automatic fire(input logic n);
    @(posedge clk);
    if (n) fire_nmi <= 1'b1;
    else fire_irq <= 1'b1;
    @(posedge clk);
    fire_nmi <= 1'b0;
    fire_irq <= 1'b0;
  endtask

  // wait for the resume pulse, check which path and how long it took
  task automatic wake(input logic en, input logic es, input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(resume_next === 1'b1 || resume_stack === 1'b1) && n < 6000);
    chk("resume_next", resume_next, en);
    chk("resume_stack", resume_stack, es);
    chk("wake_cycles", n >= lo && n <= hi, 1);
    // let the filtered request level return to idle before the next operation
    repeat (6) @(posedge clk);
  endtask

  // verdict, the one place the run ends
  task automatic stop_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  // test sequence
  initial begin
    repeat (6) @(posedge clk);
    chk("vector_in_reset", resume_vector, 1);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    bus(0, 8'h00, 0); chk("ctrl_reset", rd, 32'h1);
    chk("hresp_okay", hresp, 1'b0);
    chk("hready_high", hreadyout, 1'b1);
    bus(0, 8'h0c, 0); chk("unmapped", rd, 32'h0);
    $display("test reset done");
    core.halt_dis <= 1'b1;
    op(1); chk("nop_done", sn, 1);
    bus(0, 8'h04, 0); chk("state_run", rd, 32'h0);
    $display("test halt disabled done");
    bus(1, 8'h00, 32'h0);
    core.halt_dis <= 1'b0;
    core.irq_mask <= 1'b1;
    core.nmi_mask <= 1'b1;
    op(1); chk("halt_no_nop", sn, 0);
    bus(0, 8'h04, 0); chk("state_halt", rd, 32'h2);
    chk("clk_stopped", clk_run, 0);
    fire(0);
    repeat (20) @(posedge clk);
    bus(0, 8'h04, 0); chk("masked_irq_ignored", rd, 32'h2);
    fire(1); wake(1, 0, 4, 14);
    $display("test short nmi wake done");
    bus(1, 8'h00, 32'h1);
    core.nmi_mask <= 1'b0;
    op(1); fire(1); wake(0, 1, 4064, 4074);
    chk("clk_back", clk_run, 1);
    $display("test long nmi wake done");
    bus(1, 8'h00, 32'h0);
    core.irq_mask <= 1'b0;
    op(1); fire(0); wake(0, 1, 4, 14);
    $display("test irq wake done");
    op(1);
    bus(0, 8'h04, 0); chk("halt_before_reset", rd, 32'h2);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("reset_vector", resume_vector, 1);
    @(posedge clk) rst <= 1'b0;
    repeat (6) @(posedge clk);
    bus(0, 8'h04, 0); chk("reset_exit_run", rd, 32'h0);
    chk("reset_clk_run", clk_run, 1);
    $display("test reset wake done");
    bus(1, 8'h00, 32'h4);
    core.irq_mask <= 1'b1;
    core.nmi_mask <= 1'b0;
    core.sp <= 16'h1234;
    ss_pins_i <= 8'ha5;
    op(0); chk("stack_req", ss, 1);
    #1 chk("stall", core_stall, 1);
    chk("addr_oe", addr_oe, 1);
    chk("addr_o", addr_o, 16'h122c);
    chk("timer_off", timer_run, 0);
    chk("osc_on", clk_run, 1);
    @(posedge clk) ss_pins_i <= 8'h5a;
    repeat (5) @(posedge clk);
    chk("ss_hold", ss_pins_o, 8'ha5);
    bus(0, 8'h08, 0); chk("idle_addr_reg", rd, 32'h122c);
    bus(1, 8'h00, 32'h6);
    repeat (2) @(posedge clk);
    chk("timer_on_watchdog", timer_run, 1);
    fire(1); wake(0, 1, 0, 10);
    $display("test idle hold done");
    stop_test();
  end
endmodule // low_power_stop_wait_control_test

// file: test/lpsc_req_src.sv
// model of the external request sources: nonmaskable and maskable request pins
// assumes pins have pull-ups; a request holds its pin low until the core resumes
`timescale 1ns/10ps

module lpsc_req_src (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic fire_nmi, // pulse: raise the nonmaskable request
  input wire logic fire_irq, // pulse: raise the maskable request
  input wire logic ack, // resume pulse from the controller
  output logic nmi_n, // nonmaskable request pin, active low
  output logic irq_n // maskable request pin, active low
);
  // requests are levels held until acknowledged, released pins return high
  always_ff @(posedge clk) begin
    if (rst || ack) begin
      nmi_n <= 1'b1;
      irq_n <= 1'b1;
    end else begin
      if (fire_nmi) nmi_n <= 1'b0;
      if (fire_irq) irq_n <= 1'b0;
    end
  end
endmodule // lpsc_req_src
